// file: hw/cbs_pkg.sv
// cbs_pkg: types, field widths and timing counts for the bus cycle sequencer.
// assumes one 50 MHz core clock; every count is in internal states of that clock.
package cbs_pkg;

    // field widths
    localparam int CBS_EXT_W  = 3;
    localparam int CBS_IDLE_W = 5;

    // extension words fetched before the next instruction word
    localparam logic [CBS_EXT_W-1:0]  CBS_EXT_NONE  = 3'h0;
    localparam logic [CBS_EXT_W-1:0]  CBS_EXT_ONE   = 3'h1;
    localparam logic [CBS_EXT_W-1:0]  CBS_EXT_TWO   = 3'h2;
    localparam logic [CBS_EXT_W-1:0]  CBS_EXT_FIRST = 3'h1;

    // internal states with no bus access
    localparam logic [CBS_IDLE_W-1:0] CBS_IDLE_NONE  = 5'h00;
    localparam logic [CBS_IDLE_W-1:0] CBS_IDLE_PRE   = 5'h01;
    localparam logic [CBS_IDLE_W-1:0] CBS_IDLE_MUL_B = 5'h0B;
    localparam logic [CBS_IDLE_W-1:0] CBS_IDLE_MUL_W = 5'h13;

    typedef enum logic [3:0] {
        CBS_OP_SINGLE,
        CBS_OP_IMM_W,
        CBS_OP_IMM_L,
        CBS_OP_MUL_S_B,
        CBS_OP_MUL_S_W,
        CBS_OP_MUL_U_B,
        CBS_OP_MUL_U_W,
        CBS_OP_ST_W_IND,
        CBS_OP_ST_W_PREDEC,
        CBS_OP_LD_W_POSTINC,
        CBS_OP_ST_L_IND,
        CBS_OP_LD_L_IND,
        CBS_OP_ST_L_PREDEC,
        CBS_OP_LD_L_POSTINC,
        CBS_OP_SYNC_MOVE_FROM,
        CBS_OP_SYNC_MOVE_TO
    } cbs_op_type;

    typedef enum logic [1:0] {
        CBS_DATA_NONE,
        CBS_DATA_WORD,
        CBS_DATA_LONG
    } cbs_data_type;

    typedef enum logic [1:0] {
        CBS_SEL_FETCH_EXT,
        CBS_SEL_FETCH_NEXT,
        CBS_SEL_EA,
        CBS_SEL_EA_PLUS2
    } cbs_sel_type;

    typedef struct packed {
        logic [CBS_EXT_W-1:0]  ext;
        logic [CBS_IDLE_W-1:0] idle;
        cbs_data_type          data;
        logic                  write;
        logic                  illegal;
    } cbs_desc_type;

    function automatic cbs_desc_type cbs_decode(input cbs_op_type op);
        cbs_desc_type d;
        d = '{ext: CBS_EXT_NONE, idle: CBS_IDLE_NONE, data: CBS_DATA_NONE,
              write: 1'b0, illegal: 1'b0};
        case (op)
            CBS_OP_SINGLE:         d.ext = CBS_EXT_NONE;
            CBS_OP_IMM_W:          d.ext = CBS_EXT_ONE;
            CBS_OP_IMM_L:          d.ext = CBS_EXT_TWO;
            CBS_OP_MUL_S_B: begin
                d.ext  = CBS_EXT_ONE;
                d.idle = CBS_IDLE_MUL_B;
            end
            CBS_OP_MUL_S_W: begin
                d.ext  = CBS_EXT_ONE;
                d.idle = CBS_IDLE_MUL_W;
            end
            CBS_OP_MUL_U_B:        d.idle = CBS_IDLE_MUL_B;
            CBS_OP_MUL_U_W:        d.idle = CBS_IDLE_MUL_W;
            CBS_OP_ST_W_IND: begin
                d.data  = CBS_DATA_WORD;
                d.write = 1'b1;
            end
            CBS_OP_ST_W_PREDEC: begin
                d.idle  = CBS_IDLE_PRE;
                d.data  = CBS_DATA_WORD;
                d.write = 1'b1;
            end
            CBS_OP_LD_W_POSTINC: begin
                d.idle = CBS_IDLE_PRE;
                d.data = CBS_DATA_WORD;
            end
            CBS_OP_ST_L_IND: begin
                d.ext   = CBS_EXT_ONE;
                d.data  = CBS_DATA_LONG;
                d.write = 1'b1;
            end
            CBS_OP_LD_L_IND: begin
                d.ext  = CBS_EXT_ONE;
                d.data = CBS_DATA_LONG;
            end
            CBS_OP_ST_L_PREDEC: begin
                d.ext   = CBS_EXT_ONE;
                d.idle  = CBS_IDLE_PRE;
                d.data  = CBS_DATA_LONG;
                d.write = 1'b1;
            end
            CBS_OP_LD_L_POSTINC: begin
                d.ext  = CBS_EXT_ONE;
                d.idle = CBS_IDLE_PRE;
                d.data = CBS_DATA_LONG;
            end
            default:               d.illegal = 1'b1;
        endcase
        return d;
    endfunction

endpackage

// file: hw/cbs_idle_if.sv
// cbs_idle_if: load and completion signals between the sequencer and its idle timer.
// assumes both ends sit on the same core clock.
`timescale 1ns/1ps
interface cbs_idle_if #(parameter int IDLE_W = 5);
    logic              load;
    logic [IDLE_W-1:0] len;
    logic              done;

    modport ctrl  (output load, output len, input done);
    modport timer (input load, input len, output done);
endinterface

// file: hw/cbs_idle_timer.sv
// cbs_idle_timer: counts internal states during which no bus cycle is issued.
// assumes len is at least one whenever load is high.
`timescale 1ns/1ps
module cbs_idle_timer #(
    parameter int IDLE_W = 5
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // sequencer side
    cbs_idle_if.timer idle
);
    logic [IDLE_W-1:0] cnt_q;
    logic [IDLE_W-1:0] cnt_d;
    logic              run_q;
    logic              run_d;

    // done marks the last internal state of the run
    assign idle.done = run_q && (cnt_q == '0);

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        if (idle.load) begin
            cnt_d = idle.len - IDLE_W'(1);
            run_d = 1'b1;
        end else if (idle.done) begin
            run_d = 1'b0;
        end else if (run_q) begin
            cnt_d = cnt_q - IDLE_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end
endmodule // cbs_idle_timer

// file: hw/cbs_sequencer.sv
// cbs_sequencer: orders instruction fetches, operand accesses and internal
// states for the move, multiply and single-word register instructions.
// assumes a decoder on the same clock hands over one op at a time, and the bus
// answers each held request with a one-cycle bus_done on the same clock.
// How it works
// - byte multiply idles 11 states after next fetch
// - word multiply idles 19 states after next fetch
// - predec long store: fetches, idle, EA, EA+2
// - postinc long load: fetches, idle, EA, EA+2
// - predec word store: next fetch, idle, write
`timescale 1ns/1ps
module cbs_sequencer
    import cbs_pkg::*;
#(
    parameter int IDLE_W = 5
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    // instruction hand-over
    input  wire logic                  instr_valid,
    input  wire cbs_pkg::cbs_op_type   instr_op,
    output logic                       instr_ready,
    // bus cycle request
    output logic                       bus_req,
    output logic                       bus_write,
    output logic                       bus_lock,
    output cbs_pkg::cbs_sel_type       bus_sel,
    output logic [cbs_pkg::CBS_EXT_W-1:0] bus_ext_idx,
    input  wire logic                  bus_done,
    // status
    output logic                       busy,
    output logic                       illegal_op
);
    import cbs_pkg::*;

    // the longest idle run must fit the timer
    if ((1 << IDLE_W) <= int'(CBS_IDLE_MUL_W) || IDLE_W != CBS_IDLE_W) begin : g_chk
        $error("cbs_sequencer: IDLE_W cannot hold the longest internal run");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_EXT,
        ST_NEXT,
        ST_WAIT,
        ST_DATA1,
        ST_DATA2
    } cbs_state_type;

    cbs_state_type         state_q, state_d;
    cbs_op_type            op_q, op_d;
    logic [CBS_EXT_W-1:0]  ext_left_q, ext_left_d;
    logic [CBS_EXT_W-1:0]  ext_idx_q, ext_idx_d;
    logic                  illegal_q, illegal_d;
    cbs_desc_type          cur;
    cbs_desc_type          req;
    logic                  step;

    cbs_idle_if #(.IDLE_W(IDLE_W)) idle_bus ();

    cbs_idle_timer #(.IDLE_W(IDLE_W)) u_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .idle    (idle_bus.timer)
    );

    assign cur         = cbs_decode(op_q);
    assign req         = cbs_decode(instr_op);
    assign step        = clk_en && bus_req && bus_done;
    assign instr_ready = (state_q == ST_IDLE);
    assign busy        = (state_q != ST_IDLE);
    assign illegal_op  = illegal_q;
    assign bus_ext_idx = ext_idx_q;

    // bus request decode straight from the state flops
    always_comb begin
        bus_req   = 1'b0;
        bus_write = 1'b0;
        bus_lock  = 1'b0;
        bus_sel   = CBS_SEL_FETCH_NEXT;
        case (state_q)
            ST_EXT: begin
                bus_req = 1'b1;
                bus_sel = CBS_SEL_FETCH_EXT;
            end
            ST_NEXT: begin
                bus_req  = 1'b1;
                // long op with one extension word keeps the bus across the fetch
                bus_lock = (cur.data == CBS_DATA_LONG) && (cur.ext == CBS_EXT_ONE);
            end
            ST_DATA1: begin
                bus_req   = 1'b1;
                bus_write = cur.write;
                bus_lock  = (cur.data == CBS_DATA_LONG);
                bus_sel   = CBS_SEL_EA;
            end
            ST_DATA2: begin
                bus_req   = 1'b1;
                bus_write = cur.write;
                bus_sel   = CBS_SEL_EA_PLUS2;
            end
            default: bus_sel = CBS_SEL_FETCH_NEXT;
        endcase
    end

    always_comb begin
        state_d       = state_q;
        op_d          = op_q;
        ext_left_d    = ext_left_q;
        ext_idx_d     = ext_idx_q;
        illegal_d     = 1'b0;
        idle_bus.load = 1'b0;
        idle_bus.len  = cur.idle;
        case (state_q)
            ST_IDLE: begin
                if (instr_valid) begin
                    if (req.illegal) begin
                        // refused rather than run with an undefined bus order
                        illegal_d = 1'b1;
                    end else begin
                        op_d       = instr_op;
                        ext_left_d = req.ext;
                        ext_idx_d  = CBS_EXT_FIRST;
                        state_d    = (req.ext == CBS_EXT_NONE) ? ST_NEXT : ST_EXT;
                    end
                end
            end
            ST_EXT: begin
                if (step) begin
                    ext_left_d = ext_left_q - CBS_EXT_ONE;
                    ext_idx_d  = ext_idx_q + CBS_EXT_ONE;
                    if (ext_left_q == CBS_EXT_ONE) begin
                        state_d = ST_NEXT;
                    end
                end
            end
            ST_NEXT: begin
                if (step) begin
                    if (cur.idle != CBS_IDLE_NONE) begin
                        idle_bus.load = 1'b1;
                        state_d       = ST_WAIT;
                    end else if (cur.data != CBS_DATA_NONE) begin
                        state_d = ST_DATA1;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                if (clk_en && idle_bus.done) begin
                    state_d = (cur.data == CBS_DATA_NONE) ? ST_IDLE : ST_DATA1;
                end
            end
            ST_DATA1: begin
                if (step) begin
                    state_d = (cur.data == CBS_DATA_LONG) ? ST_DATA2 : ST_IDLE;
                end
            end
            ST_DATA2: begin
                if (step) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (!clk_en) begin
            illegal_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q    <= ST_IDLE;
            op_q       <= CBS_OP_SINGLE;
            ext_left_q <= CBS_EXT_NONE;
            ext_idx_q  <= CBS_EXT_FIRST;
            illegal_q  <= 1'b0;
        end else if (clk_en) begin
            state_q    <= state_d;
            op_q       <= op_d;
            ext_left_q <= ext_left_d;
            ext_idx_q  <= ext_idx_d;
            illegal_q  <= illegal_d;
        end
    end

    // helper for the checks: internal states spent so far in the current run
    logic [IDLE_W-1:0] wait_run_q;
    logic [IDLE_W-1:0] wait_run_d;
    logic              wait_exit;

    assign wait_exit = (state_q == ST_WAIT) && clk_en && idle_bus.done;

    always_comb begin
        wait_run_d = '0;
        if (state_q == ST_WAIT) begin
            wait_run_d = wait_run_q + IDLE_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wait_run_q <= '0;
        end else if (clk_en) begin
            wait_run_q <= wait_run_d;
        end
    end

    a_mul_byte_idle: assert property (@(posedge ref_clk) disable iff (reset)
        wait_exit && (op_q == CBS_OP_MUL_S_B || op_q == CBS_OP_MUL_U_B)
        |-> wait_run_q == CBS_IDLE_MUL_B - IDLE_W'(1))
        else $error("byte multiply idle run is not 11 states");

    a_mul_word_idle: assert property (@(posedge ref_clk) disable iff (reset)
        wait_exit && (op_q == CBS_OP_MUL_S_W || op_q == CBS_OP_MUL_U_W)
        |-> wait_run_q == CBS_IDLE_MUL_W - IDLE_W'(1))
        else $error("word multiply idle run is not 19 states");

    a_wait_no_bus: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == ST_WAIT) |-> !bus_req)
        else $error("bus request during an internal state");

    // write and lock sit in the consequent so a dropped lock cannot pass vacuously
    a_long_store_pair: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == ST_DATA1 && step && op_q == CBS_OP_ST_L_PREDEC)
        |-> (bus_write && bus_lock) ##1
            (state_q == ST_DATA2 && bus_write && bus_sel == CBS_SEL_EA_PLUS2))
        else $error("long store did not follow with write at EA+2");

    a_long_load_pair: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == ST_DATA1 && step && op_q == CBS_OP_LD_L_POSTINC)
        |-> (!bus_write && bus_lock) ##1
            (state_q == ST_DATA2 && !bus_write && bus_sel == CBS_SEL_EA_PLUS2))
        else $error("long load did not follow with read at EA+2");

    a_pre_idle_one: assert property (@(posedge ref_clk) disable iff (reset)
        wait_exit && (op_q == CBS_OP_ST_W_PREDEC || op_q == CBS_OP_ST_L_PREDEC
                      || op_q == CBS_OP_LD_L_POSTINC)
        |-> (wait_run_q == '0) ##1 (state_q == ST_DATA1 && bus_sel == CBS_SEL_EA))
        else $error("address update gap is not one state");

    a_single_one_fetch: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && instr_valid && instr_ready && instr_op == CBS_OP_SINGLE)
        |=> (state_q == ST_NEXT && bus_req && !bus_write && !bus_lock
             && bus_sel == CBS_SEL_FETCH_NEXT))
        else $error("register-only op did not start with the next fetch");

    a_single_done: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == ST_NEXT && step && op_q == CBS_OP_SINGLE) |=> state_q == ST_IDLE)
        else $error("register-only op issued more than one bus cycle");

    a_sync_refused: assert property (@(posedge ref_clk) disable iff (reset)
        (clk_en && instr_valid && instr_ready && req.illegal)
        |=> (illegal_op && state_q == ST_IDLE))
        else $error("synchronised peripheral move was not refused");

    c_mul_word: cover property (@(posedge ref_clk) disable iff (reset)
        wait_exit && op_q == CBS_OP_MUL_U_W);
    c_long_store: cover property (@(posedge ref_clk) disable iff (reset)
        state_q == ST_DATA2 && step && op_q == CBS_OP_ST_L_PREDEC);
    c_long_load: cover property (@(posedge ref_clk) disable iff (reset)
        state_q == ST_DATA2 && step && op_q == CBS_OP_LD_L_POSTINC);
    c_single: cover property (@(posedge ref_clk) disable iff (reset)
        state_q == ST_NEXT && step && op_q == CBS_OP_SINGLE);
endmodule // cbs_sequencer

// file: tb/cbs_bus_model.sv
// cbs_bus_model: memory and peripherals answering the sequencer's word cycles.
// assumes every request is held until bus_done and all parties share ref_clk.
`timescale 1ns/1ps
module cbs_bus_model (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // bus cycle request
    input  wire logic bus_req,
    input  wire logic slow,
    output logic      bus_done
);
    logic [2:0] wait_q;
    logic [2:0] dly_q;

    // a released bus never answers, so a stray done cannot hide a missing request
    assign bus_done = bus_req && (wait_q >= dly_q);

    always @(posedge ref_clk) begin
        if (reset) begin
            wait_q <= 3'h0;
            dly_q  <= 3'h0;
        end else if (clk_en && bus_done) begin
            wait_q <= 3'h0;
            dly_q  <= slow ? 3'($urandom_range(1, 4)) : 3'h0;
        end else if (clk_en && bus_req) begin
            wait_q <= wait_q + 3'h1;
        end
    end
endmodule // cbs_bus_model

// file: tb/test_cpu_bus_cycle_sequencer.sv
// test_cpu_bus_cycle_sequencer: self-checking bench for the bus cycle sequencer.
// assumes cbs_pkg is compiled first and cbs_bus_model answers the bus side.
`timescale 1ns/1ps
module test_cpu_bus_cycle_sequencer;
    import cbs_pkg::*;

    localparam int         TIMEOUT_CYCLES = 30000;
    localparam logic [7:0] REC_IDLE       = 8'hFF;

    logic                 ref_clk;
    logic                 reset;
    logic                 clk_en;
    logic                 instr_valid;
    cbs_op_type           instr_op;
    logic                 instr_ready;
    logic                 bus_req;
    logic                 bus_write;
    logic                 bus_lock;
    cbs_sel_type          bus_sel;
    logic [CBS_EXT_W-1:0] bus_ext_idx;
    logic                 bus_done;
    logic                 busy;
    logic                 illegal_op;
    logic                 slow;
    logic                 en_rand;
    int                   fail_count;
    int                   samples_checked;
    int                   cycles;
    logic [7:0]           got_q[$];
    logic [7:0]           exp_q[$];

    cbs_sequencer i_dut (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .clk_en      (clk_en),
        .instr_valid (instr_valid),
        .instr_op    (instr_op),
        .instr_ready (instr_ready),
        .bus_req     (bus_req),
        .bus_write   (bus_write),
        .bus_lock    (bus_lock),
        .bus_sel     (bus_sel),
        .bus_ext_idx (bus_ext_idx),
        .bus_done    (bus_done),
        .busy        (busy),
        .illegal_op  (illegal_op)
    );

    cbs_bus_model i_bus (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .bus_req  (bus_req),
        .slow     (slow),
        .bus_done (bus_done)
    );

    always #10 ref_clk = ~ref_clk;

    // stalls exercise the freeze path and stretch the internal-state runs
    always @(posedge ref_clk) begin
        clk_en <= en_rand ? ($urandom_range(0, 3) != 0) : 1'b1;
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES) begin
            fail_count++;
            close_out();
        end
    end

    function automatic logic [7:0] bus_rec(input logic wr, input logic lk,
                                           input cbs_sel_type sel, input logic [2:0] idx);
        return {1'b0, wr, lk, sel, idx};
    endfunction

    // one record per completed word cycle and one per enabled internal state; held requests not yet done add none
    always @(negedge ref_clk) begin
        if (!reset && clk_en && bus_req && bus_done)
            got_q.push_back(bus_rec(bus_write, bus_lock, bus_sel,
                (bus_sel == CBS_SEL_FETCH_EXT) ? bus_ext_idx : 3'h0));
        else if (!reset && clk_en && busy && !bus_req)
            got_q.push_back(REC_IDLE);
        if (!reset && illegal_op !== 1'b0)
            check("illegal_op", 32'(illegal_op), 32'h0);
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("TB: checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic expect_op(input cbs_op_type op);
        int   ext;
        int   idle;
        logic lng;
        logic dat;
        logic wr;
        ext  = (op == CBS_OP_IMM_L) ? 2 : (op inside {CBS_OP_IMM_W, CBS_OP_MUL_S_B,
               CBS_OP_MUL_S_W, CBS_OP_ST_L_IND, CBS_OP_LD_L_IND, CBS_OP_ST_L_PREDEC,
               CBS_OP_LD_L_POSTINC}) ? 1 : 0;
        idle = (op inside {CBS_OP_MUL_S_B, CBS_OP_MUL_U_B}) ? 11 :
               (op inside {CBS_OP_MUL_S_W, CBS_OP_MUL_U_W}) ? 19 :
               (op inside {CBS_OP_ST_W_PREDEC, CBS_OP_LD_W_POSTINC, CBS_OP_ST_L_PREDEC,
                           CBS_OP_LD_L_POSTINC}) ? 1 : 0;
        lng  = op inside {CBS_OP_ST_L_IND, CBS_OP_LD_L_IND, CBS_OP_ST_L_PREDEC,
                          CBS_OP_LD_L_POSTINC};
        dat  = lng || (op inside {CBS_OP_ST_W_IND, CBS_OP_ST_W_PREDEC, CBS_OP_LD_W_POSTINC});
        wr   = op inside {CBS_OP_ST_W_IND, CBS_OP_ST_W_PREDEC, CBS_OP_ST_L_IND,
                          CBS_OP_ST_L_PREDEC};
        exp_q.delete();
        for (int i = 1; i <= ext; i++)
            exp_q.push_back(bus_rec(1'b0, 1'b0, CBS_SEL_FETCH_EXT, 3'(i)));
        exp_q.push_back(bus_rec(1'b0, lng, CBS_SEL_FETCH_NEXT, 3'h0));
        repeat (idle) exp_q.push_back(REC_IDLE);
        if (dat)
            exp_q.push_back(bus_rec(wr, lng, CBS_SEL_EA, 3'h0));
        if (lng)
            exp_q.push_back(bus_rec(wr, 1'b0, CBS_SEL_EA_PLUS2, 3'h0));
    endtask

    task automatic run_op(input cbs_op_type op);
        int n;
        expect_op(op);
        got_q.delete();
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_op    <= op;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (!(instr_ready && clk_en) && n < 50);
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
        check("busy and bus_req after take", {busy, bus_req}, 32'h3);
        n = 0;
        while (instr_ready !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        // a sequence that never returns to idle counts as a mismatch here
        check("return to idle", instr_ready, 32'h1);
        check("cycle count", got_q.size(), exp_q.size());
        foreach (exp_q[i])
            check("cycle", (i < got_q.size()) ? got_q[i] : 8'h00, exp_q[i]);
    endtask

    task automatic do_reset(input int n);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (n) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        check("reset state", {instr_ready, bus_req, busy, illegal_op, bus_sel, bus_ext_idx},
              {4'h8, CBS_SEL_FETCH_NEXT, 3'h1});
    endtask

    initial begin
        void'($urandom(45890));
        ref_clk         = 1'b0;
        reset           = 1'b1;
        clk_en          = 1'b1;
        instr_valid     = 1'b0;
        instr_op        = CBS_OP_SINGLE;
        slow            = 1'b0;
        en_rand         = 1'b0;
        fail_count      = 0;
        samples_checked = 0;
        cycles          = 0;
        do_reset(16);
        // every op class once with a prompt bus; synchronised moves never offered
        for (int k = 0; k < 14; k++)
            run_op(cbs_op_type'(k));
        @(posedge ref_clk);
        slow    <= 1'b1;
        en_rand <= 1'b1;
        // reset in the middle of a word multiply
        instr_valid <= 1'b1;
        instr_op    <= CBS_OP_MUL_S_W;
        repeat (6) @(posedge ref_clk);
        instr_valid <= 1'b0;
        do_reset(2);
        repeat (150)
            run_op(cbs_op_type'($urandom_range(0, 13)));
        close_out();
    end
endmodule // test_cpu_bus_cycle_sequencer
